// *** btb_pkg.sv ***
package btb_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_CMD    = 8'h00; // command word, write starts
    localparam logic [7:0]  OFS_MEM    = 8'h04; // operand byte and waits
    localparam logic [7:0]  OFS_PC     = 8'h08; // program counter
    localparam logic [7:0]  OFS_REGS   = 8'h0C; // a, b, c, status word
    localparam logic [7:0]  OFS_STAT   = 8'h10; // status, write wakes
    localparam logic [7:0]  OFS_CLK    = 8'h14; // processor_clock_control
    // program_status_word bit positions
    localparam int          SW_IEN     = 7;     // interrupt_enable_flag
    localparam int          SW_ZERO    = 6;     // zero flag
    localparam int          SW_BNK1    = 5;     // upper bank_select_bits
    localparam int          SW_AUX     = 4;     // aux_carry_flag
    localparam int          SW_BNK0    = 3;     // lower bank_select_bits
    localparam int          SW_CAR     = 0;     // carry_flag
    // values after reset
    localparam logic [15:0] RST_PC     = 16'h0000;
    localparam logic [7:0]  RST_SW     = 8'h02;
    localparam logic [2:0]  RST_CLK    = 3'h0;
    localparam logic [2:0]  CLK_MAX    = 3'h4;  // slowest divide is 16
    // instruction lengths and cycle counts
    localparam logic [1:0]  LEN1 = 2'h1, LEN2 = 2'h2, LEN3 = 2'h3;
    localparam logic [2:0]  LEN4 = 3'h4;
    localparam logic [7:0]  CY2 = 8'h02, CY4 = 8'h04, CY6 = 8'h06;
    localparam logic [7:0]  CY8 = 8'h08, CY9 = 8'h09, CY10 = 8'h0A;
    localparam logic [7:0]  CY11 = 8'h0B, CY12 = 8'h0C;
    // axi answers
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    // operation codes
    typedef enum logic [3:0] {
        OP_NOP, OP_BSET, OP_BCLR, OP_BSTC, OP_LPB, OP_LPC, OP_LPS,
        OP_SEL, OP_ION, OP_IOFF, OP_HALT, OP_STOP
    } btb_op_t;
    // bit operand forms
    typedef enum logic [2:0] {
        FM_SADDR, FM_SFR, FM_ACC, FM_STW, FM_PTR
    } btb_form_t;
    // command word as written to OFS_CMD
    typedef struct packed {
        logic [5:0]  pad3;   // 31:26
        logic [1:0]  bank;   // bank_number
        logic [7:0]  disp;   // signed_branch_offset
        logic [2:0]  pad2;
        logic        hsram;  // operand in internal high-speed ram
        logic        pad1;
        logic [2:0]  bitn;   // tested bit
        logic        pad0;
        btb_form_t   form;
        btb_op_t     op;
    } btb_cmd_t;
    // cost of one instruction
    typedef struct packed {
        logic [2:0]  len;    // bytes
        logic [7:0]  cyc;    // cpu cycles
    } btb_cost_t;
endpackage

// *** btb_core.sv ***
//////////////////////////////////////////////////////////////////////
// Functional notes
// [RL1] cycles count cpu clock enables from divider
// [RL2] first count for high-speed ram, no access
// [RL3] second count for any other area
// [RL4] counts assume internal program rom fetch
// [RL5] pointer read adds one cycle per wait
// [RL6] pointer set-then-clear adds read, write waits
// [RL7] bit set, short direct: 3 bytes, 8/9
// [RL8] bit set, sfr: 4 bytes, 11 cycles
// [RL9] bit set, status word: 3 bytes, 9
// [RL10] bit clear, sfr: 4 bytes, 11 cycles
// [RL11] set-then-clear sfr: 4 bytes, 12, clears
// [RL12] set-then-clear accumulator: 3 bytes, 8, clears
// [RL13] set-then-clear status word: 4 bytes, flags change
// [RL14] decrement b/c, branch nonzero: 2 bytes, 6
// [RL15] disable clears, enable sets flag: 2, 6
// [RL16] bank select: 2 bytes, 4, sets bits
// [RL17] halt/stop 2 bytes 6; nop 2 cycles
//////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
module btb_core
    import btb_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    //////////////////////////////////////////////////////////////////
    // state of the whole block
    typedef enum logic { ST_IDLE, ST_EXEC } btb_fsm_t;
    typedef struct packed {
        btb_fsm_t    fsm;    // idle or executing
        btb_cmd_t    cmd;    // instruction in flight
        logic [15:0] pc;     // program counter
        logic [7:0]  a;      // accumulator
        logic [7:0]  b;      // loop register b
        logic [7:0]  c;      // loop register c
        logic [7:0]  sw;     // program_status_word
        logic [7:0]  mem;    // operand byte from memory
        logic [3:0]  wn;     // read waits
        logic [3:0]  wm;     // write waits
        logic [2:0]  clk;    // processor_clock_control
        logic [3:0]  div;    // clock divider
        logic [7:0]  cnt;    // cycles left
        logic [7:0]  last;   // cycles of last instruction
        logic        taken;  // last branch taken
        logic        halt;   // halt standby
        logic        stop;   // stop standby
        logic        wbv;    // write-back byte pending
        logic [7:0]  wb;     // write-back byte
        logic        awh;    // write address held
        logic [7:0]  awa;
        logic        wh;     // write data held
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;     // write response
        logic [1:0]  br;
        logic        rv;     // read response
        logic [31:0] rd;
        logic [1:0]  rr;
    } btb_st_t;

    btb_st_t q, d;          // registered state and its next value
    logic    cen;           // one-cycle cpu clock enable
    logic [3:0] mask;       // divider mask for the chosen rate
    btb_cost_t cost;        // cost of the command being written
    btb_cmd_t  wcmd;        // command being written
    logic      bitv;        // value of the tested bit
    logic [15:0] tgt;       // branch target
    logic [7:0]  dec;       // decremented loop value

    //////////////////////////////////////////////////////////////////
    // cost table, first or second count by area
    function automatic btb_cost_t cost_of(btb_cmd_t c, logic [3:0] n,
                                          logic [3:0] m);
        btb_cost_t r;
        r = '{len: 3'(LEN2), cyc: CY6};
        unique case (c.op)
            OP_NOP:  r = '{len: 3'(LEN1), cyc: CY2};           // [RL17]
            OP_SEL:  r = '{len: 3'(LEN2), cyc: CY4};           // [RL16]
            OP_LPB, OP_LPC, OP_ION, OP_IOFF, OP_HALT, OP_STOP:
                r = '{len: 3'(LEN2), cyc: CY6};                // [RL14] [RL15] [RL17]
            OP_LPS: r = '{len: 3'(LEN3), cyc: c.hsram ? CY8 : CY10};
            default: begin
                unique case (c.form)
                    FM_ACC: r = '{len: 3'(LEN3), cyc: CY8};    // [RL12]
                    FM_SFR: r = '{len: LEN4,                   // [RL8] [RL10] [RL11]
                                  cyc: c.op == OP_BSTC ? CY12 : CY11};
                    FM_STW: begin
                        // typed branches, no pattern inside a conditional operator
                        if (c.op == OP_BSET) begin
                            r = '{len: 3'(LEN3), cyc: CY9};    // [RL9]
                        end else begin
                            r = '{len: LEN4, cyc: c.op == OP_BSTC ? CY12 : CY11}; // [RL13]
                        end
                    end
                    FM_SADDR: begin
                        if (c.op == OP_BSET) begin
                            r = '{len: 3'(LEN3), cyc: c.hsram ? CY8 : CY9}; // [RL7] [RL2] [RL3]
                        end else begin
                            r = '{len: LEN4, cyc: c.hsram ? CY10
                                  : (c.op == OP_BSTC ? CY12 : CY11)};
                        end
                    end
                    default: begin
                        // pointer form pays the external waits
                        r.len = 3'(LEN3);
                        if (c.hsram) begin
                            r.cyc = CY10;                      // [RL2]
                        end else if (c.op == OP_BSTC) begin
                            r.cyc = CY12 + 8'(n) + 8'(m);      // [RL6]
                        end else begin
                            r.cyc = CY11 + 8'(n);              // [RL5]
                        end
                    end
                endcase
            end
        endcase
        return r;
    endfunction

    // byte-lane merge of a written word
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                          logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    //////////////////////////////////////////////////////////////////
    // cpu clock enable from the divider
    assign mask = 4'((5'h01 << q.clk) - 5'h01);
    assign cen  = (q.div & mask) == mask;                      // [RL1]

    // operand decode for the instruction in flight
    assign bitv = q.cmd.form == FM_ACC ? q.a[q.cmd.bitn]
                : q.cmd.form == FM_STW ? q.sw[q.cmd.bitn]
                : q.mem[q.cmd.bitn];
    assign dec  = (q.cmd.op == OP_LPB ? q.b
                : q.cmd.op == OP_LPC ? q.c : q.mem) - 8'h01;
    assign tgt  = q.pc + 16'(cost_of(q.cmd, q.wn, q.wm).len)
                + {{8{q.cmd.disp[7]}}, q.cmd.disp};
    assign wcmd = btb_cmd_t'(merge(32'h0, q.wd, q.ws));
    assign cost = cost_of(wcmd, q.wn, q.wm);

    //////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic        go;   // write performs this cycle
        logic        hit;  // branch condition met
        logic [31:0] w;    // merged write word
        d   = q;
        go  = q.awh && q.wh && !q.bv;
        hit = 1'b0;
        w   = 32'h0;
        d.div = q.div + 4'h1;

        // execute: count cpu cycles, commit on the last one
        if (q.fsm == ST_EXEC && cen) begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h01) begin
                d.fsm  = ST_IDLE;
                d.last = cost_of(q.cmd, q.wn, q.wm).cyc;
                d.pc   = q.pc + 16'(cost_of(q.cmd, q.wn, q.wm).len);
                unique case (q.cmd.op)
                    OP_BSET:  hit = bitv;                          // [RL7] [RL8] [RL9]
                    OP_BCLR:  hit = !bitv;                         // [RL10]
                    OP_BSTC: begin
                        hit = bitv;                                // [RL11]
                        if (bitv) begin
                            // clearing a status bit may drop zero, aux carry or carry
                            if (q.cmd.form == FM_ACC) d.a[q.cmd.bitn] = 1'b0;   // [RL12]
                            else if (q.cmd.form == FM_STW) d.sw[q.cmd.bitn] = 1'b0; // [RL13]
                            else begin
                                d.wb  = q.mem;
                                d.wb[q.cmd.bitn] = 1'b0;          // [RL11] [RL6]
                                d.wbv = 1'b1;
                            end
                        end
                    end
                    OP_LPB: begin
                        d.b = dec;                                 // [RL14]
                        hit = dec != 8'h00;
                    end
                    OP_LPC: begin
                        d.c = dec;                                 // [RL14]
                        hit = dec != 8'h00;
                    end
                    OP_LPS: begin
                        d.wb  = dec;
                        d.wbv = 1'b1;
                        hit   = dec != 8'h00;
                    end
                    OP_SEL: begin
                        d.sw[SW_BNK1] = q.cmd.bank[1];             // [RL16]
                        d.sw[SW_BNK0] = q.cmd.bank[0];
                    end
                    OP_ION:  d.sw[SW_IEN] = 1'b1;                  // [RL15]
                    OP_IOFF: d.sw[SW_IEN] = 1'b0;                  // [RL15]
                    OP_HALT: d.halt = 1'b1;                        // [RL17]
                    OP_STOP: d.stop = 1'b1;                        // [RL17]
                    default: ;
                endcase
                d.taken = hit;
                if (hit) d.pc = tgt;
            end
        end

        // write channels, either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.awh = 1'b1;
            d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wh = 1'b1;
            d.wd = s_axi_wdata;
            d.ws = s_axi_wstrb;
        end
        if (go) begin
            d.awh = 1'b0;
            d.wh  = 1'b0;
            d.bv  = 1'b1;
            d.br  = RESP_OKAY;
            unique case (q.awa)
                OFS_CMD: begin
                    // refused while busy or in standby
                    if (q.fsm == ST_EXEC || q.halt || q.stop) begin
                        d.br = RESP_SLV;
                    end else begin
                        d.cmd   = wcmd;
                        d.cnt   = cost.cyc;                        // [RL4]
                        d.fsm   = ST_EXEC;
                        d.wbv   = 1'b0;
                    end
                end
                OFS_MEM: begin
                    w    = merge({16'h0, q.wm, q.wn, q.mem}, q.wd, q.ws);
                    d.mem = w[7:0];
                    d.wn  = w[11:8];
                    d.wm  = w[15:12];
                end
                OFS_PC: begin
                    w    = merge({16'h0, q.pc}, q.wd, q.ws);
                    d.pc = w[15:0];
                end
                OFS_REGS: begin
                    w = merge({q.sw, q.c, q.b, q.a}, q.wd, q.ws);
                    {d.sw, d.c, d.b, d.a} = w;
                end
                OFS_STAT: begin
                    // bit 0 wakes the core from standby
                    // a standby entered in this same cycle survives the wake
                    if (q.ws[0] && q.wd[0]) begin
                        d.halt = d.halt && !q.halt;
                        d.stop = d.stop && !q.stop;
                    end
                end
                OFS_CLK: begin
                    if (q.ws[0] && q.wd[2:0] <= CLK_MAX) d.clk = q.wd[2:0];
                    else if (q.ws[0]) d.br = RESP_SLV;
                end
                default: d.br = RESP_SLV;
            endcase
        end
        if (q.bv && s_axi_bready) d.bv = 1'b0;

        // read channel, one cycle to answer
        if (s_axi_arvalid && s_axi_arready) begin
            d.rv = 1'b1;
            d.rr = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_CMD:  d.rd = q.cmd;
                OFS_MEM:  d.rd = {16'h0, q.wm, q.wn, q.mem};
                OFS_PC:   d.rd = {16'h0, q.pc};
                OFS_REGS: d.rd = {q.sw, q.c, q.b, q.a};
                OFS_STAT: d.rd = {8'h00, q.last, q.wb, 3'h0, q.wbv, q.stop,
                                  q.halt, q.taken, q.fsm == ST_EXEC};
                OFS_CLK:  d.rd = {29'h0, q.clk};
                default: begin
                    d.rd = 32'h0;
                    d.rr = RESP_SLV;
                end
            endcase
        end else if (q.rv && s_axi_rready) begin
            d.rv = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q     <= '0;
            q.fsm <= ST_IDLE;
            q.pc  <= RST_PC;
            q.sw  <= RST_SW;
            q.clk <= RST_CLK;
        end else begin
            q <= d;
        end
    end

    // bus outputs; ready terms are combinational
    assign s_axi_awready = !q.awh && !q.bv;
    assign s_axi_wready  = !q.wh && !q.bv;
    assign s_axi_bvalid  = q.bv;
    assign s_axi_bresp   = q.br;
    assign s_axi_arready = !q.rv;
    assign s_axi_rvalid  = q.rv;
    assign s_axi_rdata   = q.rd;
    assign s_axi_rresp   = q.rr;

endmodule // btb_core

// *** btb_core_monitor.sv ***
////////////////////////////////////////////////////////////////////////////////
// bus timing watch on the instruction block's register port
module btb_core_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so one clock and one reset for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned one cycle after address");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing two cycles after address and data");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before it was taken");
    a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated after it was taken");
    a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated after it was taken");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code outside okay and slave error");
endmodule // btb_core_chk
bind btb_core btb_core_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** btb_mem_model.sv ***
////////////////////////////////////////////////////////////////////////////////
// operand memory: byte and wait counts the core would see on its data access
module btb_mem_model (
    // slot picked by the bench
    input wire logic [2:0]  slot,
    // operand word: write waits, read waits, byte
    output logic     [31:0] mem_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // lookup only; program fetch is internal rom, so no fetch waits exist
    always_comb begin
        case (slot)
            3'h0:    mem_word = 32'h0000_0001; // bit 0 set
            3'h1:    mem_word = 32'h0000_0080; // bit 7 set
            3'h2:    mem_word = 32'h0000_00FB; // bit 2 clear
            3'h3:    mem_word = 32'h0000_0008; // bit 3 set
            3'h4:    mem_word = 32'h0000_0301; // external, three read waits
            3'h5:    mem_word = 32'h0000_1210; // external, two read and one write wait
            default: mem_word = 32'h0000_0000; // no operand
        endcase
    end
endmodule // btb_mem_model

// *** btb_tb.sv ***
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module tb;
    import btb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RG = 32'h0200_0581; // status 02, c 00, b 05, a 81
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;                // byte addresses
    logic [31:0] wdata, rdata, mem_word, d;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  slot;                          // operand slot in the model
    int          err_total, n_checks, cyc;
    btb_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    btb_mem_model u_mem (.slot(slot), .mem_word(mem_word));
    // free-running clock, 10 ns
    always #5 aclk = ~aclk;
    // hang guard: far above the thousand or so cycles the tests need
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // handshakes sampled at the falling edge, where nothing moves, then acted on at the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        int t;
        bh = 0;
        t = 0;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; wstrb <= 4'hF; bready <= 1'b1;
        while (!bh && t < 100) begin
            @(negedge aclk);
            ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready; rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
            t++;
        end
        if (!bh) err_total++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ah, hs;
        int t;
        hs = 0;
        t = 0;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        while (!hs && t < 100) begin
            @(negedge aclk);
            ah = arvalid && arready; hs = rvalid && rready; v = rdata; rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (hs) rready <= 1'b0;
            t++;
        end
        if (!hs) err_total++;
    endtask
    // load state, issue one instruction, wait for commit, compare results
    task automatic ex(input btb_op_t op, input btb_form_t f, input logic [2:0] b, input logic hs,
        input logic [7:0] dp, input logic [1:0] bk, input logic [2:0] sl, input logic [31:0] rg,
        input logic [15:0] epc, input logic [7:0] ecy, input logic et, input logic [31:0] erg,
        input logic [8:0] ewb);
        btb_cmd_t c;
        int t;
        c = '0; c.op = op; c.form = f; c.bitn = b; c.hsram = hs; c.disp = dp; c.bank = bk;
        slot = sl;
        wr(OFS_PC, 32'h0000_0100, r);
        wr(OFS_REGS, rg, r);
        wr(OFS_MEM, mem_word, r);
        wr(OFS_CMD, c, r);
        `CHK("cmd resp", RESP_OKAY, r)
        d = 32'h1;
        for (t = 0; t < 300 && d[0] !== 1'b0; t++) rd(OFS_STAT, d, r);
        rd(OFS_PC, d, r); `CHK("pc", epc, d[15:0])
        rd(OFS_STAT, d, r); `CHK("cycles", ecy, d[23:16])
        if (et !== 1'bx) `CHK("taken", et, d[1])
        if (ewb[8]) `CHK("write-back", ewb[7:0], d[15:8])
        `CHK("wb valid", ewb[8], d[4])
        rd(OFS_REGS, d, r); `CHK("regs", erg, d)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; slot = 3'h7;
        err_total = 0; n_checks = 0; cyc = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_REGS, d, r); `CHK("status reset", RST_SW, d[31:24])
        ex(OP_BSET, FM_SADDR, 3'h0, 1'b1, 8'h10, 2'h0, 3'h0, RG, 16'h0113, CY8, 1'b1, RG, 9'h000);
        ex(OP_BSET, FM_SADDR, 3'h1, 1'b0, 8'h10, 2'h0, 3'h0, RG, 16'h0103, CY9, 1'b0, RG, 9'h000);
        ex(OP_BSET, FM_SFR, 3'h7, 1'b0, 8'h10, 2'h0, 3'h1, RG, 16'h0114, CY11, 1'b1, RG, 9'h000);
        ex(OP_BSET, FM_STW, 3'h1, 1'b0, 8'h10, 2'h0, 3'h7, RG, 16'h0113, CY9, 1'b1, RG, 9'h000);
        ex(OP_BCLR, FM_SFR, 3'h2, 1'b0, 8'hF0, 2'h0, 3'h2, RG, 16'h00F4, CY11, 1'b1, RG, 9'h000);
        ex(OP_BCLR, FM_SADDR, 3'h2, 1'b1, 8'h10, 2'h0, 3'h2, RG, 16'h0114, CY10, 1'b1, RG, 9'h000);
        ex(OP_BSTC, FM_SFR, 3'h3, 1'b0, 8'h10, 2'h0, 3'h3, RG, 16'h0114, CY12, 1'b1, RG, 9'h100);
        ex(OP_BSTC, FM_ACC, 3'h7, 1'b1, 8'h10, 2'h0, 3'h7, RG, 16'h0113, CY8, 1'b1, 32'h0200_0501, 9'h000);
        ex(OP_BSTC, FM_STW, 3'h0, 1'b0, 8'h10, 2'h0, 3'h7, 32'h0300_0581, 16'h0114, CY12, 1'b1, RG, 9'h000);
        ex(OP_BSET, FM_PTR, 3'h0, 1'b0, 8'h10, 2'h0, 3'h4, RG, 16'h0113, 8'h0E, 1'b1, RG, 9'h000);
        ex(OP_BSTC, FM_PTR, 3'h4, 1'b0, 8'h10, 2'h0, 3'h5, RG, 16'h0113, 8'h0F, 1'b1, RG, 9'h100);
        ex(OP_LPB, FM_SADDR, 3'h0, 1'b1, 8'h10, 2'h0, 3'h7, RG, 16'h0112, CY6, 1'b1, 32'h0200_0481, 9'h000);
        ex(OP_LPC, FM_SADDR, 3'h0, 1'b1, 8'h10, 2'h0, 3'h7, 32'h0201_0581, 16'h0102, CY6, 1'b0, RG, 9'h000);
        ex(OP_LPS, FM_SADDR, 3'h0, 1'b0, 8'h10, 2'h0, 3'h0, RG, 16'h0103, CY10, 1'b0, RG, 9'h100);
        ex(OP_ION, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h0, 3'h7, RG, 16'h0102, CY6, 1'bx, 32'h8200_0581, 9'h000);
        ex(OP_IOFF, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h0, 3'h7, 32'h8200_0581, 16'h0102, CY6, 1'bx, RG, 9'h000);
        ex(OP_SEL, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h3, 3'h7, RG, 16'h0102, CY4, 1'bx, 32'h2A00_0581, 9'h000);
        ex(OP_NOP, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h0, 3'h7, RG, 16'h0101, CY2, 1'bx, RG, 9'h000);
        // standby flag set, new instruction refused, then woken by status write
        for (int k = 0; k < 2; k++) begin
            ex(k ? OP_STOP : OP_HALT, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h0, 3'h7, RG, 16'h0102, CY6, 1'bx, RG, 9'h000);
            rd(OFS_STAT, d, r); `CHK("standby", (k ? 2'h2 : 2'h1), d[3:2])
            wr(OFS_CMD, 32'h0, r); `CHK("refused", RESP_SLV, r)
            wr(OFS_STAT, 32'h1, r);
            rd(OFS_STAT, d, r); `CHK("woken", 2'h0, d[3:2])
        end
        // halved cpu clock still reports cpu cycles; bad divide code refused
        wr(OFS_CLK, 32'h1, r); `CHK("clk resp", RESP_OKAY, r)
        ex(OP_NOP, FM_SADDR, 3'h0, 1'b1, 8'h00, 2'h0, 3'h7, RG, 16'h0101, CY2, 1'bx, RG, 9'h000);
        wr(OFS_CLK, 32'h5, r); `CHK("clk bad", RESP_SLV, r)
        rd(OFS_CLK, d, r); `CHK("clk kept", 3'h1, d[2:0])
        wr(OFS_CLK, 32'h0, r);
        rd(8'h18, d, r); `CHK("unmapped", {RESP_SLV, 32'h0}, {r, d})
        end_sim();
    end
endmodule // tb
